/* File: design/cvan_core.sv */
// Card answer-to-reset sequencer with class and factor registers.
`timescale 1ns/1ps
module cvan_core
    import cvan_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CARD_RST_PIN,
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic TX_READY,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic APP_VALID,
    input wire logic [7:0] APP_DATA,
    output logic APP_READY,
    output logic IRQ
);
    logic rst_s1_r;
    logic rst_s2_r;
    logic rst_s3_r;
    cvan_state_t state_r;
    cvan_state_t state_nxt;
    logic [3:0] idx_r;
    logic [3:0] idx_nxt;
    logic [7:0] tx_data_r;
    logic [7:0] tx_data_nxt;
    logic tx_valid_r;
    logic tx_valid_nxt;
    logic [7:0] rom_data;
    logic [4:0] cls_r;
    logic [4:0] cls_nxt;
    logic [7:0] ta1_r;
    logic [7:0] ta1_nxt;
    logic enable_r;
    logic enable_nxt;
    logic [2:0] irq_r;
    logic [2:0] irq_nxt;
    logic [2:0] mask_r;
    logic [2:0] mask_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [7:0] bytes_r;
    logic [7:0] bytes_nxt;
    logic card_rst_n;
    logic rst_rise;
    logic atr_done;
    logic cls_gap;
    logic [4:0] wcls;

    // The reset pin is asynchronous to the core clock, so two flops first.
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
            rst_s3_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= CARD_RST_PIN;
            rst_s2_r <= rst_s1_r;
            rst_s3_r <= rst_s2_r;
        end
    end

    assign card_rst_n = rst_s2_r;
    assign rst_rise = rst_s2_r & ~rst_s3_r;

    cvan_atr_rom u_rom
    (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .addr(idx_nxt),
        .ta1(ta1_r),
        .cls(cls_r),
        .rdata(rom_data)
    );

    // A class set with holes would mislead the terminal's class search.
    function automatic logic gap_of(input logic [4:0] c);
        logic seen;
        logic ended;
        logic bad;
        seen = 1'b0;
        ended = 1'b0;
        bad = 1'b0;
        for (int i = 0; i < CVAN_CLS_W; i++)
        begin
            if (c[i] && ended)
                bad = 1'b1;
            if (c[i])
                seen = 1'b1;
            else if (seen)
                ended = 1'b1;
        end
        return bad;
    endfunction

    assign wcls = WDATA[4:0];
    assign cls_gap = gap_of(wcls);

    // Answer sequencer: the answer string goes out before any app byte.
    always_comb
    begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        tx_valid_nxt = tx_valid_r;
        tx_data_nxt = tx_data_r;
        atr_done = 1'b0;
        if (!card_rst_n)
        begin
            state_nxt = CVAN_IDLE;
            idx_nxt = 4'h0;
            tx_valid_nxt = 1'b0;
        end
        else
        begin
            case (state_r)
                CVAN_IDLE:
                    if (rst_rise && enable_r)
                        state_nxt = CVAN_WAIT;
                CVAN_WAIT:
                begin
                    // The store is addressed by the next index, so its
                    // registered output already holds the byte at idx_r.
                    tx_data_nxt = rom_data;
                    tx_valid_nxt = 1'b1;
                    state_nxt = CVAN_SEND;
                end
                CVAN_SEND:
                    if (tx_valid_r && TX_READY)
                    begin
                        tx_valid_nxt = 1'b0;
                        if (idx_r == 4'(CVAN_IDX_TCK))
                        begin
                            atr_done = 1'b1;
                            state_nxt = CVAN_APP;
                        end
                        else
                        begin
                            idx_nxt = idx_r + 4'h1;
                            state_nxt = CVAN_WAIT;
                        end
                    end
                default:
                begin
                    tx_valid_nxt = APP_VALID;
                    tx_data_nxt = APP_DATA;
                    if (tx_valid_r && !TX_READY)
                    begin
                        tx_valid_nxt = tx_valid_r;
                        tx_data_nxt = tx_data_r;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            state_r <= CVAN_IDLE;
            idx_r <= 4'h0;
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            tx_valid_r <= tx_valid_nxt;
            tx_data_r <= tx_data_nxt;
        end
    end

    // Application bytes pass only once the answer is out.
    assign APP_READY = (state_r == CVAN_APP) && (!tx_valid_r || TX_READY);
    assign TX_VALID = tx_valid_r;
    assign TX_DATA = tx_data_r;

    // Register file, interrupt flags and read path.
    always_comb
    begin
        cls_nxt = cls_r;
        ta1_nxt = ta1_r;
        enable_nxt = enable_r;
        mask_nxt = mask_r;
        irq_nxt = irq_r;
        bytes_nxt = bytes_r;
        rdata_nxt = 32'h0;
        if (WR)
        begin
            if (ADDR == CVAN_A_CTRL)
                enable_nxt = WDATA[0];
            else if (ADDR == CVAN_A_CLASS)
            begin
                // A class set with a hole is refused and flagged.
                if (!cls_gap)
                    cls_nxt = wcls;
            end
            else if (ADDR == CVAN_A_TA1)
                ta1_nxt = WDATA[7:0];
            else if (ADDR == CVAN_A_IRQ)
                irq_nxt = irq_r & ~WDATA[2:0];
            else if (ADDR == CVAN_A_MASK)
                mask_nxt = WDATA[2:0];
        end
        if (atr_done)
            bytes_nxt = bytes_r + 8'h01;
        // Hardware sets win over a same-cycle software clear.
        if (atr_done)
            irq_nxt[CVAN_IRQ_DONE] = 1'b1;
        if (rst_rise)
            irq_nxt[CVAN_IRQ_RST] = 1'b1;
        if (WR && ADDR == CVAN_A_CLASS && cls_gap)
            irq_nxt[CVAN_IRQ_GAP] = 1'b1;
        if (RD)
        begin
            if (ADDR == CVAN_A_CTRL)
                rdata_nxt = {31'h0, enable_r};
            else if (ADDR == CVAN_A_CLASS)
                rdata_nxt = {27'h0, cls_r};
            else if (ADDR == CVAN_A_TA1)
                rdata_nxt = {24'h0, ta1_r};
            else if (ADDR == CVAN_A_STAT)
                rdata_nxt = {28'h0, idx_r[1:0], state_r};
            else if (ADDR == CVAN_A_IRQ)
                rdata_nxt = {29'h0, irq_r};
            else if (ADDR == CVAN_A_MASK)
                rdata_nxt = {29'h0, mask_r};
            else if (ADDR == CVAN_A_BYTE)
                rdata_nxt = {24'h0, bytes_r};
            else
                rdata_nxt = 32'h0;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            cls_r <= CVAN_CLS_RST;
            ta1_r <= CVAN_TA1_RST;
            enable_r <= 1'b1;
            mask_r <= 3'h0;
            irq_r <= 3'h0;
            bytes_r <= 8'h00;
            rdata_r <= 32'h0;
        end
        else
        begin
            cls_r <= cls_nxt;
            ta1_r <= ta1_nxt;
            enable_r <= enable_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
            bytes_r <= bytes_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;
    assign IRQ = |(irq_r & mask_r);
endmodule

/* File: design/cvan_pkg.sv */
// Package of constants for the card answer-to-reset generator.
package cvan_pkg;
    localparam logic [7:0] CVAN_TS = 8'h3b;
    // T0: TA1 and TD1 present, 9 historical bytes fill the 16-byte answer.
    localparam logic [7:0] CVAN_T0 = 8'h99;
    // TA1 default: Fi 512, Di 8; software may program 512,16 instead.
    localparam logic [7:0] CVAN_TA1_RST = 8'h94;
    localparam logic [7:0] CVAN_TD1 = 8'h80;
    localparam logic [7:0] CVAN_TD2 = 8'h1f;
    localparam logic [7:0] CVAN_CATEGORY = 8'h80;
    localparam logic [7:0] CVAN_TAG_CDS = 8'h31;
    localparam logic [7:0] CVAN_CDS_VAL = 8'he0;
    localparam logic [7:0] CVAN_TAG_CAP = 8'h73;
    localparam logic [7:0] CVAN_CAP_B0 = 8'hfe;
    localparam logic [7:0] CVAN_CAP_B1 = 8'h21;
    localparam int CVAN_ATR_LEN = 16;
    localparam int CVAN_IDX_TA1 = 2;
    localparam int CVAN_IDX_TA3 = 5;
    localparam int CVAN_IDX_TCK = 15;
    localparam int CVAN_CLS_W = 5;
    localparam logic [4:0] CVAN_CLS_RST = 5'h03;
    // Register map.
    localparam logic [3:0] CVAN_A_CTRL = 4'h0;
    localparam logic [3:0] CVAN_A_CLASS = 4'h1;
    localparam logic [3:0] CVAN_A_TA1 = 4'h2;
    localparam logic [3:0] CVAN_A_STAT = 4'h3;
    localparam logic [3:0] CVAN_A_IRQ = 4'h4;
    localparam logic [3:0] CVAN_A_MASK = 4'h5;
    localparam logic [3:0] CVAN_A_BYTE = 4'h6;
    localparam int CVAN_IRQ_DONE = 0;
    localparam int CVAN_IRQ_RST = 1;
    localparam int CVAN_IRQ_GAP = 2;
    typedef enum logic [1:0]
    {
        CVAN_IDLE = 2'b00,
        CVAN_SEND = 2'b01,
        CVAN_WAIT = 2'b11,
        CVAN_APP = 2'b10
    } cvan_state_t;
endpackage

/* File: design/cvan_atr_rom.sv */
// Small answer-to-reset byte store with registered read data.
`timescale 1ns/1ps
module cvan_atr_rom
    import cvan_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] ta1,
    input wire logic [4:0] cls,
    output logic [7:0] rdata
);
    logic [7:0] rom_nxt;
    logic [7:0] tck;
    logic [7:0] rdata_r;

    // Check byte is the exclusive or of T0 through the last historical byte.
    always_comb
    begin
        tck = CVAN_T0 ^ ta1 ^ CVAN_TD1 ^ CVAN_TD2 ^ {3'h0, cls} ^ CVAN_CATEGORY
            ^ CVAN_TAG_CDS ^ CVAN_CDS_VAL ^ CVAN_TAG_CAP ^ CVAN_CAP_B0
            ^ CVAN_CAP_B1 ^ 8'h00;
        case (addr)
            4'h0: rom_nxt = CVAN_TS;
            4'h1: rom_nxt = CVAN_T0;
            4'h2: rom_nxt = ta1;
            4'h3: rom_nxt = CVAN_TD1;
            4'h4: rom_nxt = CVAN_TD2;
            4'h5: rom_nxt = {3'h0, cls};
            4'h6: rom_nxt = CVAN_CATEGORY;
            4'h7: rom_nxt = CVAN_TAG_CDS;
            4'h8: rom_nxt = CVAN_CDS_VAL;
            4'h9: rom_nxt = CVAN_TAG_CAP;
            4'ha: rom_nxt = CVAN_CAP_B0;
            4'hb: rom_nxt = CVAN_CAP_B1;
            4'hc: rom_nxt = 8'h00;
            4'hd: rom_nxt = 8'h00;
            4'he: rom_nxt = 8'h00;
            default: rom_nxt = tck;
        endcase
    end

    // Read data come out of a register.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_r <= 8'h00;
        else
            rdata_r <= rom_nxt;
    end

    assign rdata = rdata_r;
endmodule

/* File: sim/cvan_terminal.sv */
// Terminal model that resets the card and collects the answer bytes.
`timescale 1ns/1ps
module cvan_terminal
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic stall,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic card_rst,
    output logic tx_ready,
    output int cnt
);
    logic [7:0] buf_q [0:15];
    logic [2:0] cls_r;
    logic [1:0] bad_r;
    logic [7:0] x_r;
    logic tgl_r;
    // Stalling on every other cycle can make the card hold the first byte; later bytes fall two cycles apart and meet a ready cycle.
    // Only default factors are used, so no parameter selection starts.
    assign tx_ready = card_rst && (!stall || tgl_r);
    // Reset control, byte capture and class bookkeeping.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            card_rst <= 1'b0;
            cnt <= 0;
            tgl_r <= 1'b0;
            cls_r <= 3'h0;
            bad_r <= 2'h0;
            x_r <= 8'h00;
        end
        else
        begin
            card_rst <= go;
            tgl_r <= ~tgl_r;
            if (!go)
            begin
                cnt <= 0;
                x_r <= 8'h00;
            end
            else if (tx_valid && tx_ready && cnt < 16)
            begin
                buf_q[cnt] <= tx_data;
                cnt <= cnt + 1;
                if (cnt > 0 && cnt < 15)
                    x_r <= x_r ^ tx_data;
                if (cnt == 15 && tx_data != x_r)
                begin
                    // Two corrupted answers in a row are retried at the same class; the third moves the next try up a step.
                    if (bad_r == 2'h2)
                    begin
                        bad_r <= 2'h0;
                        cls_r <= cls_r + 3'h1;
                    end
                    else
                        bad_r <= bad_r + 2'h1;
                end
                else if (cnt == 15)
                begin
                    bad_r <= 2'h0;
                    // A class the card lacks moves the next try up a step.
                    // An empty class byte means class A only.
                    if (buf_q[5][4:0] != 5'h00 && !buf_q[5][cls_r])
                        cls_r <= cls_r + 3'h1;
                end
            end
        end
    end
endmodule

/* File: sim/cvan_checker.sv */
// Checker of the answer bytes that the card sends after reset.
`timescale 1ns/1ps
module cvan_checker
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CARD_RST_PIN,
    input wire logic TX_READY,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA
);
    int n_r;
    int n_nxt;
    logic [5:0] c;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // Class field widened so the contiguity test cannot overflow.
    assign c = {1'b0, TX_DATA[4:0]};
    // Index of the next answer byte; cleared only once the card is idle.
    always_comb
    begin
        n_nxt = n_r;
        if (!CARD_RST_PIN && !TX_VALID)
            n_nxt = 0;
        else if (TX_VALID && TX_READY && n_r < 16)
            n_nxt = n_r + 1;
    end
    // Registered byte index.
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            n_r <= 0;
        else
            n_r <= n_nxt;
    end
    property p_first;
        TX_VALID && n_r == 0 |-> TX_DATA == 8'h3b;
    endproperty
    a_first: assert property (p_first)
        else $error("first byte wrong");
    property p_hold;
        TX_VALID && !TX_READY && n_r < 16 |=> TX_VALID && $stable(TX_DATA);
    endproperty
    a_hold: assert property (p_hold)
        else $error("byte not held");
    property p_t15;
        TX_VALID && n_r == 4 |-> TX_DATA[3:0] == 4'hf;
    endproperty
    a_t15: assert property (p_t15)
        else $error("no T=15 group");
    property p_ta1;
        TX_VALID && n_r == 2 |-> TX_DATA == 8'h94;
    endproperty
    a_ta1: assert property (p_ta1)
        else $error("factor byte wrong");
    property p_fac;
        TX_VALID && n_r == 2 |-> TX_DATA[7:4] == 4'h9;
    endproperty
    a_fac: assert property (p_fac)
        else $error("factor F wrong");
    property p_cls;
        TX_VALID && n_r == 5 |-> TX_DATA[7:5] == 3'h0 && c != 6'h00;
    endproperty
    a_cls: assert property (p_cls)
        else $error("class byte");
    property p_gap;
        TX_VALID && n_r == 5 |-> (((c | (c - 6'h01)) + 6'h01) & c) == 6'h00;
    endproperty
    a_gap: assert property (p_gap)
        else $error("class gap");
    property p_cat;
        TX_VALID && n_r == 6 |-> TX_DATA == 8'h80;
    endproperty
    a_cat: assert property (p_cat)
        else $error("category wrong");
    property p_tag;
        TX_VALID && (n_r == 7 || n_r == 9) |->
            TX_DATA == (n_r == 7 ? 8'h31 : 8'h73);
    endproperty
    a_tag: assert property (p_tag)
        else $error("tag");
endmodule
bind cvan_core cvan_checker i_cvan_checker (.CORE_CLK(CORE_CLK),
    .RST_N(RST_N), .CARD_RST_PIN(CARD_RST_PIN), .TX_READY(TX_READY),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA));

/* File: sim/cvan_core_tb_top.sv */
// Testbench of the card answer sequencer and its registers.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR %0t mismatch", $time); end end
module cvan_core_tb_top;
    import cvan_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic go = 1'b0;
    logic stall = 1'b0;
    logic card_rst, tx_ready, tx_valid, irq;
    logic [7:0] tx_data;
    logic [31:0] rdata;
    int cnt, err_count = 0, check_count = 0, cyc = 0;
    localparam logic [7:0] ATR [16] = '{8'h3b, 8'h99, 8'h94, 8'h80,
        8'h1f, 8'h03, 8'h80, 8'h31, 8'he0, 8'h73, 8'hfe, 8'h21,
        8'h00, 8'h00, 8'h00, 8'h00};
    always #20 clk = ~clk;
    cvan_terminal i_cvan_terminal (.clk(clk), .rst_n(rst_n), .go(go),
        .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
        .card_rst(card_rst), .tx_ready(tx_ready), .cnt(cnt));
    cvan_core i_cvan_core (.CORE_CLK(clk), .RST_N(rst_n),
        .CARD_RST_PIN(card_rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd_s), .RDATA(rdata), .TX_READY(tx_ready), .TX_VALID(tx_valid),
        .TX_DATA(tx_data), .APP_VALID(1'b0), .APP_DATA(8'h00),
        .APP_READY(), .IRQ(irq));
    task wrap_up;
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // A hung run is cut short and counted as a failure.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rd_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task t_reset;
        rd_reg(CVAN_A_CTRL, 32'h1);
        rd_reg(CVAN_A_CLASS, 32'h3);
        rd_reg(CVAN_A_TA1, 32'h94);
        rd_reg(CVAN_A_IRQ, 32'h0);
        rd_reg(4'hf, 32'h0);
        wr_reg(CVAN_A_MASK, 32'h7);
        rd_reg(CVAN_A_MASK, 32'h7);
    endtask
    // Runs one answer with the given class and checks every byte.
    task t_atr(input logic [4:0] c, input logic s);
        logic [7:0] e;
        logic [7:0] x;
        int k;
        stall <= s;
        go <= 1'b1;
        x = 8'h00;
        k = 0;
        while (cnt < 16 && k < 500)
        begin
            @(posedge clk);
            k++;
        end
        for (int i = 0; i < 16; i++)
        begin
            e = (i == 5) ? {3'h0, c} : ATR[i];
            if (i == 15)
                e = x;
            else if (i > 0)
                x = x ^ e;
            `CHK(i_cvan_terminal.buf_q[i], e)
        end
        repeat (2) @(posedge clk);
        #1 `CHK(irq, 1'b1)
        rd_reg(CVAN_A_IRQ, 32'h3);
        wr_reg(CVAN_A_IRQ, 32'h3);
        rd_reg(CVAN_A_IRQ, 32'h0);
        #1 `CHK(irq, 1'b0)
        go <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // A class set with a hole is refused and flagged.
    task t_gap;
        wr_reg(CVAN_A_CLASS, 32'h5);
        rd_reg(CVAN_A_CLASS, 32'h3);
        rd_reg(CVAN_A_IRQ, 32'h4);
        #1 `CHK(irq, 1'b1)
        wr_reg(CVAN_A_IRQ, 32'h4);
        wr_reg(CVAN_A_CLASS, 32'h6);
        rd_reg(CVAN_A_CLASS, 32'h6);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_atr(5'h03, 1'b0);
        t_gap();
        t_atr(5'h06, 1'b1);
        wrap_up();
    end
endmodule
